// file: astx_tx.sv
// Asynchronous serial transmitter with its register port and pin control
// Assumes a register master that keeps strobes one cycle long, never both
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ps
`include "astx_defines.svh"

// How it works
// - Sends only with tx_enable set, sync clear and serial port enabled.
// - Serial port enable forces tx_pin to output, ignoring its direction bit.
// - Serial port enable forces rx_pin to input; port latch cannot drive it.
// - Setting tx_enable makes the buffer-empty flag set, holding register empty.
// - Holding write starts sending; idle shift register loads it at once.
// - Busy shift register: new byte waits, loads right after stop bit.
// - After a load, start bit, data bits, then stop bit go out.
// - Buffer-empty flag high while tx_enable set and no byte waits in the holding register.
// - Flag may lag a write; correct after two instruction cycles.
// - Buffer-empty flag is read-only; writes never change it.
// - Flag sets regardless of irq enable; enable only gates the request.
// - Flag set plus irq enable plus global and peripheral enables interrupts.
// - Shift-empty flag set when idle, cleared on load until all sent.
// - Shift-empty flag raises no interrupt; software polls it.
// - Nine-bit select sends 9 data bits; ninth bit is the MSB.
// - Nine-bit mode captures ninth bit and byte together at load.
// - Shift register has no address; reached only via holding register.
// - Line idles mark; start space, data LSB first, stop at mark.
// - Data leaves least significant bit first in a shared format.
// - Each bit lasts BIT_CLKS clocks of a local counter, not the baud generator.
module astx_tx
  import astx_pkg::*;
#(
  parameter int BIT_CLKS = `ASTX_BIT_CLKS_DEF
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire astx_req_t req,
  output logic [7:0] rdata,
  // Port C pins
  input wire logic [7:0] portc_in,
  input wire logic [7:0] portc_latch,
  output logic [7:0] portc_out,
  output logic [7:0] portc_oe,
  // Interrupt request toward the core
  output logic tx_irq,
  // Baud settings for the shared generator
  output logic [7:0] baud_divisor,
  output logic high_baud_select
);

  // ------------------------------------------------------------
  // Registers and decode
  // ------------------------------------------------------------
  logic [7:0] intctl_ff;
  logic [7:0] irqen_ff;
  logic [7:0] rxctl_ff;
  logic [7:0] baud_ff;
  logic [7:0] dirc_ff;
  logic [7:0] txctl_ff;
  logic [7:0] hold_ff;
  logic hold_full_ff;
  logic [8:0] shift_ff;
  logic shift_empty_ff;
  astx_state_t state_ff;
  logic [3:0] bit_idx_ff;
  logic [15:0] baud_cnt_ff;
  logic line_ff;
  logic [7:0] lag_ff;
  logic txf_ff;
  logic [7:0] rdata_ff;

  logic wr_hold;
  logic serial_port_enable;
  logic tx_enable;
  logic nine_bit_tx_select;
  logic tx_run;
  logic bit_done;
  logic last_data;
  logic load;
  logic nxt_txf;
  logic [3:0] nbits;

  assign wr_hold = req.wr && (req.addr == `ASTX_OFF_HOLD);
  assign serial_port_enable = rxctl_ff[`ASTX_RX_PORTEN];
  assign tx_enable = txctl_ff[`ASTX_TX_EN];
  assign nine_bit_tx_select = txctl_ff[`ASTX_TX_NINE];
  assign tx_run = tx_enable && !txctl_ff[`ASTX_TX_SYNC]
    && serial_port_enable;
  assign nbits = nine_bit_tx_select ? 4'h9 : 4'h8;
  assign bit_done = (baud_cnt_ff == 16'(BIT_CLKS - 1));
  assign last_data = (bit_idx_ff == nbits - 4'h1);
  // Load when the shifter is idle, or on the final stop-bit clock
  assign load = tx_run && hold_full_ff &&
    ((state_ff == ASTX_IDLE) ||
     (state_ff == ASTX_STOP && bit_done));

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      intctl_ff <= `ASTX_RST_BYTE;
      irqen_ff <= `ASTX_RST_BYTE;
      rxctl_ff <= `ASTX_RST_BYTE;
      baud_ff <= `ASTX_RST_BYTE;
      dirc_ff <= `ASTX_RST_DIRC;
      txctl_ff <= `ASTX_RST_TXCTL;
    end
    else if (req.wr)
    begin
      unique case (req.addr)
        `ASTX_OFF_INTCTL: intctl_ff <= req.wdata;
        `ASTX_OFF_IRQEN: irqen_ff <= req.wdata;
        `ASTX_OFF_RXCTL: rxctl_ff <= req.wdata;
        `ASTX_OFF_BAUD: baud_ff <= req.wdata;
        `ASTX_OFF_DIRC: dirc_ff <= req.wdata;
        // Shift-empty status bit is not writable
        `ASTX_OFF_TXCTL: txctl_ff <= req.wdata & `ASTX_TXCTL_WMASK;
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Holding register
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      hold_ff <= `ASTX_RST_BYTE;
      hold_full_ff <= 1'b0;
    end
    else if (wr_hold)
    begin
      hold_ff <= req.wdata;
      hold_full_ff <= 1'b1;
    end
    else if (load || !tx_enable)
    begin
      // Dropping tx_enable discards a queued byte; the buffer-empty flag reads clear
      hold_full_ff <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Shifter: start, data LSB first, stop
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff <= ASTX_IDLE;
      shift_ff <= 9'h000;
      bit_idx_ff <= 4'h0;
      baud_cnt_ff <= 16'h0000;
      line_ff <= 1'b1;
      shift_empty_ff <= 1'b1;
    end
    else if (load)
    begin
      // Ninth bit sampled at load time together with the byte
      shift_ff <= {txctl_ff[`ASTX_TX_D9], hold_ff};
      state_ff <= ASTX_START;
      baud_cnt_ff <= 16'h0000;
      bit_idx_ff <= 4'h0;
      line_ff <= 1'b0;
      shift_empty_ff <= 1'b0;
    end
    else if (!tx_run)
    begin
      state_ff <= ASTX_IDLE;
      line_ff <= 1'b1;
      shift_empty_ff <= 1'b1;
    end
    else if (state_ff != ASTX_IDLE)
    begin
      baud_cnt_ff <= bit_done ? 16'h0000 : baud_cnt_ff + 16'h0001;
      if (bit_done)
      begin
        unique case (state_ff)
          ASTX_START:
          begin
            state_ff <= ASTX_DATA;
            line_ff <= shift_ff[0];
          end
          ASTX_DATA:
          begin
            if (last_data)
            begin
              state_ff <= ASTX_STOP;
              line_ff <= 1'b1;
            end
            else
            begin
              shift_ff <= {1'b0, shift_ff[8:1]};
              line_ff <= shift_ff[1];
              bit_idx_ff <= bit_idx_ff + 4'h1;
            end
          end
          ASTX_STOP:
          begin
            state_ff <= ASTX_IDLE;
            shift_empty_ff <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Buffer-empty flag with write lag
  // ------------------------------------------------------------
  // The flag follows the queue, but is held stale for up to two
  // instruction cycles after a holding write, as the core would see it.
  assign nxt_txf = tx_enable && !hold_full_ff;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lag_ff <= 8'h00;
      txf_ff <= 1'b0;
    end
    else
    begin
      if (wr_hold)
        lag_ff <= 8'(`ASTX_FLAG_LAG - 1);
      else if (lag_ff != 8'h00)
        lag_ff <= lag_ff - 8'h01;
      // Refresh outside the lag; a disable always clears at once
      if (lag_ff == 8'h00 && !wr_hold || !tx_enable)
        txf_ff <= nxt_txf;
    end
  end

  // Only the buffer-empty flag requests interrupts; shift-empty never does
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      tx_irq <= 1'b0;
    else
      tx_irq <= txf_ff && irqen_ff[`ASTX_IRQEN_TX]
        && intctl_ff[`ASTX_INT_GLOBAL]
        && intctl_ff[`ASTX_INT_PERIPH];
  end

  // ------------------------------------------------------------
  // Read data, one cycle after the read strobe
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata_ff <= 8'h00;
    else if (req.rd)
    begin
      unique case (req.addr)
        `ASTX_OFF_INTCTL: rdata_ff <= intctl_ff;
        `ASTX_OFF_IRQEN: rdata_ff <= irqen_ff;
        `ASTX_OFF_IRQFLG: rdata_ff <= 8'(txf_ff) << `ASTX_PIR_TXF;
        `ASTX_OFF_RXCTL: rdata_ff <= rxctl_ff;
        `ASTX_OFF_BAUD: rdata_ff <= baud_ff;
        `ASTX_OFF_DIRC: rdata_ff <= dirc_ff;
        `ASTX_OFF_TXCTL: rdata_ff <= txctl_ff
          | (8'(shift_empty_ff) << `ASTX_TX_SHEMPTY);
        // Holding register is write-only; unmapped reads give zero
        default: rdata_ff <= 8'h00;
      endcase
    end
    else
      rdata_ff <= 8'h00;
  end
  assign rdata = rdata_ff;

  // ------------------------------------------------------------
  // Pin control
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_pin
      if (gi == `ASTX_TX_PIN)
      begin : g_tx
        assign portc_oe[gi] = serial_port_enable || !dirc_ff[gi];
        assign portc_out[gi] = serial_port_enable ? line_ff
          : portc_latch[gi];
      end
      else if (gi == `ASTX_RX_PIN)
      begin : g_rx
        assign portc_oe[gi] = !serial_port_enable && !dirc_ff[gi];
        assign portc_out[gi] = serial_port_enable ? 1'b0
          : portc_latch[gi];
      end
      else
      begin : g_gp
        assign portc_oe[gi] = !dirc_ff[gi];
        assign portc_out[gi] = portc_latch[gi];
      end
    end
  endgenerate

  assign baud_divisor = baud_ff;
  assign high_baud_select = txctl_ff[`ASTX_TX_HIGH];

endmodule

// file: astx_defines.svh
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by the transmitter module, its checker and the bench
`ifndef ASTX_DEFINES_SVH
`define ASTX_DEFINES_SVH

// ------------------------------------------------------------
// Register offsets (4-bit register port address)
// ------------------------------------------------------------
`define ASTX_OFF_INTCTL 4'h0
`define ASTX_OFF_IRQEN 4'h1
`define ASTX_OFF_IRQFLG 4'h2
`define ASTX_OFF_RXCTL 4'h3
`define ASTX_OFF_BAUD 4'h4
`define ASTX_OFF_DIRC 4'h5
`define ASTX_OFF_HOLD 4'h6
`define ASTX_OFF_TXCTL 4'h7

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define ASTX_INT_GLOBAL 7
`define ASTX_INT_PERIPH 6
`define ASTX_IRQEN_TX 4
`define ASTX_PIR_TXF 4
`define ASTX_RX_PORTEN 7
`define ASTX_TX_NINE 6
`define ASTX_TX_EN 5
`define ASTX_TX_SYNC 4
`define ASTX_TX_HIGH 2
`define ASTX_TX_SHEMPTY 1
`define ASTX_TX_D9 0
`define ASTX_TX_PIN 6
`define ASTX_RX_PIN 7

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define ASTX_RST_BYTE 8'h00
`define ASTX_RST_DIRC 8'hFF
`define ASTX_RST_TXCTL 8'h02
// Bit 3 is unimplemented and bit 1 is status: neither is writable
`define ASTX_TXCTL_WMASK 8'hF5

// ------------------------------------------------------------
// Timing: clock 200 MHz, instruction cycle 4 clocks
// ------------------------------------------------------------
`define ASTX_CLK_MHZ 200
`define ASTX_TCY_NS 20
`define ASTX_TCY_CLKS ((`ASTX_TCY_NS * `ASTX_CLK_MHZ + 999) / 1000)
`define ASTX_FLAG_LAG (2 * `ASTX_TCY_CLKS)
`define ASTX_BIT_CLKS_DEF 16

`endif

// file: astx_pkg.sv
// Types shared by the async transmitter
// Assumes astx_defines.svh sits in the same folder
package astx_pkg;

  typedef enum logic [1:0]
  {
    ASTX_IDLE = 2'b00,
    ASTX_START = 2'b01,
    ASTX_DATA = 2'b11,
    ASTX_STOP = 2'b10
  } astx_state_t;

  typedef struct packed
  {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } astx_req_t;

  typedef struct packed
  {
    logic out;
    logic oe;
  } astx_pin_t;

endpackage

// file: astx_tx_chk.sv
// Port checker for the async transmitter
// Assumes bind into astx_tx; registers are shadowed from writes
`timescale 1ns/1ps
`include "astx_defines.svh"
module astx_tx_chk
  import astx_pkg::*;
#(
  parameter int BIT_CLKS = `ASTX_BIT_CLKS_DEF
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire astx_req_t req,
  input wire logic [7:0] rdata,
  // Pins and status
  input wire logic [7:0] portc_out,
  input wire logic [7:0] portc_oe,
  input wire logic tx_irq,
  input wire logic [7:0] baud_divisor,
  input wire logic high_baud_select
);
  logic [7:0] ic_ff, ie_ff, rx_ff, bd_ff, tx_ff;
  int run_ff;
  logic en;
  assign en = rx_ff[7] && tx_ff[5] && !tx_ff[4];
  // Shadows, since the checker cannot see the register bank
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      ic_ff <= 8'h00;
      ie_ff <= 8'h00;
      rx_ff <= 8'h00;
      bd_ff <= 8'h00;
      tx_ff <= 8'h02;
    end
    else if (req.wr)
    begin
      if (req.addr == `ASTX_OFF_INTCTL) ic_ff <= req.wdata;
      if (req.addr == `ASTX_OFF_IRQEN) ie_ff <= req.wdata;
      if (req.addr == `ASTX_OFF_RXCTL) rx_ff <= req.wdata;
      if (req.addr == `ASTX_OFF_BAUD) bd_ff <= req.wdata;
      if (req.addr == `ASTX_OFF_TXCTL) tx_ff <= req.wdata;
    end
  // Low runs lie inside frames only, so their length is checkable
  always_ff @(posedge clk or posedge rst)
    if (rst) run_ff <= 0;
    else if (portc_out[6] || !rx_ff[7]) run_ff <= 0;
    else run_ff <= run_ff + 1;
  // ----
  // Assertions
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_rdata_quiet: assert property (!$past(req.rd) |-> rdata == 8'h00)
    else $error("read data outside read slot");
  a_tx_drive: assert property (rx_ff[7] |-> portc_oe[6])
    else $error("tx pin not driven");
  a_rx_input: assert property (rx_ff[7] |-> !portc_oe[7])
    else $error("rx pin driven");
  a_line_idle: assert property (
    $past(!en) && !en && rx_ff[7] |-> portc_out[6])
    else $error("line active while disabled");
  a_bit_len: assert property ($rose(portc_out[6]) && $past(rx_ff[7]) |->
    run_ff % BIT_CLKS == 0 && run_ff != 0 && run_ff <= 10 * BIT_CLKS)
    else $error("low run not whole bits");
  a_baud_copy: assert property (baud_divisor == bd_ff &&
    high_baud_select == tx_ff[2])
    else $error("baud copy wrong");
  a_irq_gate: assert property (!(ie_ff[4] && ic_ff[7] && ic_ff[6]) |=> !tx_irq)
    else $error("irq without enables");
  a_irq_txoff: assert property (!tx_ff[5] [*2] |=> !tx_irq)
    else $error("irq with tx off");
  c_start: cover property ($fell(portc_out[6]) && rx_ff[7]);
  c_queue: cover property (req.wr && req.addr == `ASTX_OFF_HOLD && !portc_out[6]);
  c_irq: cover property (tx_irq);
endmodule

bind astx_tx astx_tx_chk #(.BIT_CLKS(BIT_CLKS)) u_chk (.clk(clk), .rst(rst),
  .req(req), .rdata(rdata), .portc_out(portc_out), .portc_oe(portc_oe),
  .tx_irq(tx_irq), .baud_divisor(baud_divisor),
  .high_baud_select(high_baud_select));

// file: astx_rx_model.sv
// Remote receiver model sampling the transmit line
// Assumes the line idles high and BIT_CLKS matches the sender
`timescale 1ns/1ps
module astx_rx_model
#(
  parameter int BIT_CLKS = 4
)
(
  // Clock and line
  input wire logic clk,
  input wire logic line,
  // Format and results
  input wire logic nine,
  output logic [8:0] data,
  output int frames,
  output int ferr
);
  logic [8:0] sh;
  int i;
  initial
  begin
    data = 9'h000;
    frames = 0;
    ferr = 0;
    forever
    begin
      @(negedge line);
      // Mid-bit sampling keeps a clock of skew harmless
      repeat (BIT_CLKS / 2) @(posedge clk);
      if (!line)
      begin
        sh = 9'h000;
        for (i = 0; i < (nine ? 9 : 8); i++)
        begin
          repeat (BIT_CLKS) @(posedge clk);
          sh[i] = line;
        end
        repeat (BIT_CLKS) @(posedge clk);
        if (!line) ferr++;
        data = sh;
        frames++;
      end
    end
  end
endmodule

// file: astx_tx_tb.sv
// Self-checking bench for the async transmitter
// Assumes the receiver model and checker compile first
`timescale 1ns/1ps
`include "astx_defines.svh"
module astx_tx_tb;
  import astx_pkg::*;
  localparam int BC = 4;
  logic clk, rst, nine, tx_irq, hbs;
  astx_req_t req;
  logic [7:0] rdata, out, oe, bd;
  logic [8:0] rx_data;
  int frames, ferr, err_count, checked, cyc, f0;
  astx_tx #(.BIT_CLKS(BC)) DUT (.clk(clk), .rst(rst), .req(req),
    .rdata(rdata), .portc_in(out), .portc_latch(8'h4A), .portc_out(out),
    .portc_oe(oe), .tx_irq(tx_irq), .baud_divisor(bd),
    .high_baud_select(hbs));
  astx_rx_model #(.BIT_CLKS(BC)) u_rx (.clk(clk), .line(out[6]),
    .nine(nine), .data(rx_data), .frames(frames), .ferr(ferr));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      wrap_up;
    end
  end
  task cmp(input logic [8:0] g, input logic [8:0] e);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 cmp({1'b0, rdata}, {1'b0, e});
  endtask
  task wait_frame(input logic [8:0] e, input int lim);
    int n;
    f0 = frames;
    n = 0;
    while (frames == f0 && n < lim)
    begin
      @(posedge clk);
      n++;
    end
    cmp(frames != f0 ? rx_data : 9'bx, e);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task t_reset;
    rd(`ASTX_OFF_TXCTL, 8'h02);
    rd(`ASTX_OFF_DIRC, 8'hFF);
    wr(`ASTX_OFF_IRQFLG, 8'hFF);
    wr(`ASTX_OFF_TXCTL, 8'h00);
    rd(`ASTX_OFF_IRQFLG, 8'h00);
    rd(`ASTX_OFF_TXCTL, 8'h02);
    rd(`ASTX_OFF_HOLD, 8'h00);
    rd(4'hC, 8'h00);
    $display("test reset done");
  endtask
  task t_enable;
    wr(`ASTX_OFF_DIRC, 8'h0F);
    wr(`ASTX_OFF_BAUD, 8'h9C);
    wr(`ASTX_OFF_TXCTL, 8'h04);
    wr(`ASTX_OFF_RXCTL, 8'h80);
    wr(`ASTX_OFF_TXCTL, 8'h24);
    rd(`ASTX_OFF_IRQFLG, 8'h10);
    cmp({bd, hbs}, 9'h139);
    cmp({7'h00, oe[7:6]}, 9'h001);
    $display("test enable done");
  endtask
  task t_frame;
    wr(`ASTX_OFF_HOLD, 8'hA5);
    rd(`ASTX_OFF_TXCTL, 8'h24);
    wait_frame(9'h0A5, 60);
    repeat (BC) @(posedge clk);
    rd(`ASTX_OFF_TXCTL, 8'h26);
    $display("test frame done");
  endtask
  task t_b2b;
    wr(`ASTX_OFF_HOLD, 8'h11);
    wr(`ASTX_OFF_HOLD, 8'h22);
    repeat (10) @(posedge clk);
    rd(`ASTX_OFF_IRQFLG, 8'h00);
    wait_frame(9'h011, 60);
    wait_frame(9'h022, 44);
    rd(`ASTX_OFF_IRQFLG, 8'h10);
    $display("test back to back done");
  endtask
  task t_nine;
    nine <= 1'b1;
    wr(`ASTX_OFF_TXCTL, 8'h65);
    wr(`ASTX_OFF_HOLD, 8'h3C);
    wait_frame(9'h13C, 64);
    repeat (BC) @(posedge clk);
    wr(`ASTX_OFF_TXCTL, 8'h24);
    nine <= 1'b0;
    $display("test nine done");
  endtask
  task t_irq;
    wr(`ASTX_OFF_IRQEN, 8'h10);
    wr(`ASTX_OFF_INTCTL, 8'hC0);
    @(posedge clk);
    #1 cmp({8'h00, tx_irq}, 9'h001);
    wr(`ASTX_OFF_IRQEN, 8'h00);
    repeat (2) @(posedge clk);
    #1 cmp({8'h00, tx_irq}, 9'h000);
    rd(`ASTX_OFF_IRQFLG, 8'h10);
    wr(`ASTX_OFF_INTCTL, 8'h00);
    $display("test irq done");
  endtask
  task t_off;
    wr(`ASTX_OFF_TXCTL, 8'h34);
    wr(`ASTX_OFF_HOLD, 8'h55);
    f0 = frames;
    repeat (60) @(posedge clk);
    cmp(9'(frames - f0), 9'h000);
    wr(`ASTX_OFF_TXCTL, 8'h04);
    rd(`ASTX_OFF_IRQFLG, 8'h00);
    cmp(9'(ferr), 9'h000);
    $display("test off done");
  endtask
  initial
  begin
    rst = 1'b1;
    nine = 1'b0;
    req = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_enable;
    t_frame;
    t_b2b;
    t_nine;
    t_irq;
    t_off;
    wrap_up;
  end
endmodule
